// file: dmr_pkg.sv
// mode and extended configuration register constants for the ddr2 mode register block
// assumes address bits a0..a13 and bank bits ba0..ba2 arrive on the command clock
package dmr_pkg;

  localparam int MR_W = 14;

  // main mode register fields
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_TEST_BIT = 7;
  localparam int MR_DLLRST_BIT = 8;
  localparam int MR_WR_LSB = 9;
  localparam int MR_RSV_BIT = 13;

  // extended_config_one fields
  localparam int X1_DLLOFF_BIT = 0;
  localparam int X1_HALF_BIT = 1;
  localparam int X1_TERM0_BIT = 2;
  localparam int X1_PCD_LSB = 3;
  localparam int X1_TERM1_BIT = 6;
  localparam int X1_CAL_LSB = 7;
  localparam int X1_NSTRB_BIT = 10;
  localparam int X1_RSTRB_BIT = 11;
  localparam int X1_RSV_BIT = 13;

  // encodings
  localparam logic [2:0] BL_FOUR = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam logic [2:0] CAL_EXIT = 3'h0;
  localparam logic [2:0] CAL_ADJUST = 3'h4;
  localparam logic [2:0] CAL_DEFAULT = 3'h7;

  // values after reset and counts
  localparam logic [MR_W-1:0] REG_RST = 14'h0000;
  localparam int DLL_LOCK_CYCLES = 200;

  // bundle carried from the command clock to mclk
  localparam int BUNDLE_W = 4 * MR_W + 5;

  typedef enum logic [2:0] {
    DMR_CMD_NONE,
    DMR_CMD_MODE,
    DMR_CMD_EXT1,
    DMR_CMD_EXT2,
    DMR_CMD_EXT3
  } dmr_cmd_t;

endpackage : dmr_pkg

// file: dmr_bundle_sync.sv
// toggle handshake carrying a word from the command clock domain to mclk
// assumes the source presents a level; only the latest value is guaranteed to arrive
`timescale 1ns/100ps
module dmr_bundle_sync #(
  parameter int DW = 8
) (
  input wire logic srcClk, // source clock
  input wire logic srcRstN, // source synchronous reset, active low
  input wire logic [DW-1:0] srcData, // level to transport
  input wire logic dstClk, // destination clock
  input wire logic dstRstN, // destination synchronous reset, active low
  output logic [DW-1:0] dstData // last delivered word
);

  typedef struct packed {
    logic [DW-1:0] hold;
    logic req;
    logic busy;
    logic ackMeta;
    logic ackSync;
  } dmr_src_t;

  typedef struct packed {
    logic [DW-1:0] data;
    logic reqMeta;
    logic reqSync;
    logic reqSeen;
  } dmr_dst_t;

  dmr_src_t src_r, src_nxt;
  dmr_dst_t dst_r, dst_nxt;

  if (DW < 1) begin : g_chk
    $error("dmr_bundle_sync: DW must be positive");
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    src_nxt = src_r;
    src_nxt.ackMeta = dst_r.reqSeen;
    src_nxt.ackSync = src_r.ackMeta;
    if (src_r.busy && (src_r.ackSync == src_r.req)) begin
      src_nxt.busy = 1'b0;
    end else if (!src_r.busy && (srcData != src_r.hold)) begin
      // hold stays stable until the far side has acknowledged
      src_nxt.hold = srcData;
      src_nxt.req = ~src_r.req;
      src_nxt.busy = 1'b1;
    end
    if (!srcRstN) begin
      src_nxt = '0;
    end
  end

  always_ff @(posedge srcClk) begin
    src_r <= src_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    dst_nxt = dst_r;
    dst_nxt.reqMeta = src_r.req;
    dst_nxt.reqSync = dst_r.reqMeta;
    if (dst_r.reqSync != dst_r.reqSeen) begin
      dst_nxt.data = src_r.hold;
      dst_nxt.reqSeen = dst_r.reqSync;
    end
    if (!dstRstN) begin
      dst_nxt = '0;
    end
  end

  always_ff @(posedge dstClk) begin
    dst_r <= dst_nxt;
  end

  assign dstData = dst_r.data;

endmodule // dmr_bundle_sync

// file: dmr_mode_regs.sv
// ddr2 device side: captures mode and extended configuration writes from the command pins
// assumes command pins are launched by the controller on cmdClk; settings are reported on mclk
`timescale 1ns/100ps

// What the document requires
// R1 - controller holds clock enable, termination low; the model drives clock enable low but has no termination pin
// R2 - controller waits 200us, then raises clock enable
// R3 - controller idles 400ns then precharges all
// R4 - controller loads extended two then three
// R5 - controller enables delay loop, calibration off
// R6 - controller resets delay loop through main register
// R7 - controller precharges, then two auto refreshes
// R8 - controller rewrites main register without loop reset
// R9 - calibration default then exit, 200 clocks later
// R10 - every rewrite supplies all fields
// R11 - registers count only after first write
// R12 - main register load on all-low command
// R13 - writes only when idle, clock enable high
// R14 - burst length, ordering, read latency decoded
// R15 - test bit, loop reset, recovery, reserved bit
// R16 - recovery cycles rounded up by controller
// R17 - extended one load with bank zero high
// R18 - extended one fields decoded as laid out
// R19 - controller exits calibration with zero code
// R20 - adjust keeps previous posted column delay
// R21 - read strobe replaces mask on byte parts
// R22 - strobe matrix from bits ten and eleven
// R23 - controller leaves two clocks after writes
// R24 - reads wait 200 clocks after loop reset
// R25 - controller zeroes reserved extended bits
// R26 - controller counts waits in whole clocks
// R27 - controller signals done after final write; the model has no done signal, the bench ends the test itself
module dmr_mode_regs #(
  parameter int BYTE_WIDE = 1, // 1: byte-wide part with read strobe pins
  parameter int LOCK_CYCLES = dmr_pkg::DLL_LOCK_CYCLES // clocks from loop reset to ready
) (
  input wire logic mclk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic cmdClk, // command clock from the controller
  input wire logic cke, // clock enable pin
  input wire logic csN, // chip select, active low
  input wire logic rasN, // row strobe, active low
  input wire logic casN, // column strobe, active low
  input wire logic weN, // write enable, active low
  input wire logic [2:0] ba, // bank address
  input wire logic [15:0] addr, // address pins
  output logic modeValid, // main register written since reset
  output logic ext1Valid, // extended_config_one written
  output logic ext2Valid, // extended_config_two written
  output logic ext3Valid, // extended_config_three written
  output logic burstEight, // burst length eight
  output logic burstInterleave, // interleaved burst order
  output logic [2:0] readLatency, // column read latency code
  output logic [2:0] writeRecovery, // auto-precharge recovery code
  output logic modeError, // illegal burst, test mode or reserved bit set
  output logic dllEnabled, // delay loop enabled
  output logic dllReady, // loop reset has settled
  output logic halfDrive, // half strength driver
  output logic [2:0] postedColumnDelay, // posted column delay
  output logic [1:0] termCode, // termination value, {a6, a2}
  output logic [2:0] calControl, // driver_impedance_calibration code
  output logic maskEnable, // write_byte_mask pin acts as mask
  output logic readOnlyStrobeOn, // read_only_strobe drives during reads
  output logic readStrobeCompOn, // complementary read_only_strobe drives
  output logic strobeCompOn, // complementary data strobe drives
  output logic [dmr_pkg::MR_W-1:0] ext2Value, // extended_config_two contents
  output logic [dmr_pkg::MR_W-1:0] ext3Value // extended_config_three contents
);
  import dmr_pkg::*;

  localparam int CW = $clog2(LOCK_CYCLES + 1);
  localparam logic [CW-1:0] LOCK_LOAD = CW'(LOCK_CYCLES);

  if (BYTE_WIDE != 0 && BYTE_WIDE != 1) begin : g_chk_bw
    $error("dmr_mode_regs: BYTE_WIDE must be 0 or 1");
  end
  if (LOCK_CYCLES < 1) begin : g_chk_lock
    $error("dmr_mode_regs: LOCK_CYCLES must be at least 1");
  end

  //////////////////////////////////////////////////////////////////////////////
  // command clock side

  typedef struct packed {
    logic rstMeta;
    logic rstSync;
    logic [MR_W-1:0] mode;
    logic [MR_W-1:0] ext1;
    logic [MR_W-1:0] ext2;
    logic [MR_W-1:0] ext3;
    logic [3:0] written;
    logic [CW-1:0] lockCnt;
    logic locked;
  } dmr_link_t;

  dmr_link_t lnk_r, lnk_nxt;

  function automatic dmr_cmd_t decodeCmd(input logic en, input logic cs, input logic ras,
                                         input logic cas, input logic we,
                                         input logic [1:0] bank);
    dmr_cmd_t c;
    c = DMR_CMD_NONE;
    if (en && !cs && !ras && !cas && !we) begin
      case (bank)
        2'h0: c = DMR_CMD_MODE; // [R12]
        2'h1: c = DMR_CMD_EXT1; // [R17]
        2'h2: c = DMR_CMD_EXT2;
        2'h3: c = DMR_CMD_EXT3;
        default: c = DMR_CMD_NONE;
      endcase
    end
    return c;
  endfunction

  dmr_cmd_t cmd;
  logic [MR_W-1:0] addrLow;

  assign addrLow = addr[MR_W-1:0];
  // writes are only taken with clock enable high
  assign cmd = decodeCmd(cke, csN, rasN, casN, weN, ba[1:0]); // [R13]

  always_comb begin
    lnk_nxt = lnk_r;
    lnk_nxt.rstMeta = nrst;
    lnk_nxt.rstSync = lnk_r.rstMeta;
    if (lnk_r.lockCnt != '0) begin
      lnk_nxt.lockCnt = lnk_r.lockCnt - CW'(1);
      lnk_nxt.locked = (lnk_r.lockCnt == CW'(1));
    end
    case (cmd)
      DMR_CMD_MODE: begin
        // whole register replaced on every write
        lnk_nxt.mode = addrLow; // [R12] [R10]
        lnk_nxt.written[0] = 1'b1;
        if (addrLow[MR_DLLRST_BIT]) begin
          // loop reset drops ready for the lock period
          lnk_nxt.lockCnt = LOCK_LOAD; // [R15] [R24]
          lnk_nxt.locked = 1'b0;
        end
      end
      DMR_CMD_EXT1: begin
        lnk_nxt.ext1 = addrLow; // [R17] [R10]
        lnk_nxt.written[1] = 1'b1;
        if (addrLow[X1_CAL_LSB +: 3] == CAL_ADJUST) begin
          // adjust keeps the posted delay already in force
          lnk_nxt.ext1[X1_PCD_LSB +: 3] = lnk_r.ext1[X1_PCD_LSB +: 3]; // [R20]
        end
        if (addrLow[X1_DLLOFF_BIT]) begin
          lnk_nxt.locked = 1'b0;
          lnk_nxt.lockCnt = '0;
        end
      end
      DMR_CMD_EXT2: begin
        lnk_nxt.ext2 = addrLow;
        lnk_nxt.written[2] = 1'b1;
      end
      DMR_CMD_EXT3: begin
        lnk_nxt.ext3 = addrLow;
        lnk_nxt.written[3] = 1'b1;
      end
      default: begin
      end
    endcase
    if (!lnk_r.rstSync) begin
      // registers loaded with REG_RST until written; valid bits cleared
      lnk_nxt.mode = REG_RST; // [R11]
      lnk_nxt.ext1 = REG_RST;
      lnk_nxt.ext2 = REG_RST;
      lnk_nxt.ext3 = REG_RST;
      lnk_nxt.written = '0;
      lnk_nxt.lockCnt = '0;
      lnk_nxt.locked = 1'b0;
    end
  end

  always_ff @(posedge cmdClk) begin
    lnk_r <= lnk_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // crossing to mclk

  logic [BUNDLE_W-1:0] bundleSrc;
  logic [BUNDLE_W-1:0] bundleDst;

  assign bundleSrc = {lnk_r.locked, lnk_r.written, lnk_r.ext3, lnk_r.ext2, lnk_r.ext1,
                      lnk_r.mode};

  dmr_bundle_sync #(
    .DW(BUNDLE_W)
  ) u_sync (
    .srcClk(cmdClk),
    .srcRstN(lnk_r.rstSync),
    .srcData(bundleSrc),
    .dstClk(mclk),
    .dstRstN(nrst),
    .dstData(bundleDst)
  );

  logic [MR_W-1:0] mMode;
  logic [MR_W-1:0] mExt1;
  logic [MR_W-1:0] mExt2;
  logic [MR_W-1:0] mExt3;
  logic [3:0] mWritten;
  logic mLocked;

  assign mMode = bundleDst[0 +: MR_W];
  assign mExt1 = bundleDst[MR_W +: MR_W];
  assign mExt2 = bundleDst[2 * MR_W +: MR_W];
  assign mExt3 = bundleDst[3 * MR_W +: MR_W];
  assign mWritten = bundleDst[4 * MR_W +: 4];
  assign mLocked = bundleDst[4 * MR_W + 4];

  //////////////////////////////////////////////////////////////////////////////
  // mclk side: decoded settings, each output a flip-flop

  typedef struct packed {
    logic modeValid;
    logic ext1Valid;
    logic ext2Valid;
    logic ext3Valid;
    logic burstEight;
    logic burstInterleave;
    logic [2:0] readLatency;
    logic [2:0] writeRecovery;
    logic modeError;
    logic dllEnabled;
    logic dllReady;
    logic halfDrive;
    logic [2:0] postedColumnDelay;
    logic [1:0] termCode;
    logic [2:0] calControl;
    logic maskEnable;
    logic readOnlyStrobeOn;
    logic readStrobeCompOn;
    logic strobeCompOn;
    logic [MR_W-1:0] ext2Value;
    logic [MR_W-1:0] ext3Value;
  } dmr_core_t;

  dmr_core_t core_r, core_nxt;

  logic rdStrobe;
  logic [2:0] burstCode;

  assign burstCode = mMode[MR_BL_LSB +: 3];
  // read strobe only exists on byte-wide parts
  assign rdStrobe = mWritten[1] && (BYTE_WIDE == 1) && mExt1[X1_RSTRB_BIT]; // [R21]

  always_comb begin
    core_nxt = core_r;
    core_nxt.modeValid = mWritten[0]; // [R11]
    core_nxt.ext1Valid = mWritten[1];
    core_nxt.ext2Valid = mWritten[2];
    core_nxt.ext3Valid = mWritten[3];
    // fields only take effect once their register is written
    core_nxt.burstEight = mWritten[0] && (burstCode == BL_EIGHT); // [R14]
    core_nxt.burstInterleave = mWritten[0] && mMode[MR_BT_BIT]; // [R14]
    core_nxt.readLatency = mWritten[0] ? mMode[MR_CL_LSB +: 3] : 3'h0; // [R14]
    core_nxt.writeRecovery = mWritten[0] ? mMode[MR_WR_LSB +: 3] : 3'h0; // [R15]
    core_nxt.modeError = (mWritten[0] && ((burstCode != BL_FOUR && burstCode != BL_EIGHT)
                          || mMode[MR_TEST_BIT] || mMode[MR_RSV_BIT]))
                         || (mWritten[1] && mExt1[X1_RSV_BIT]); // [R15] [R18]
    core_nxt.dllEnabled = mWritten[1] && !mExt1[X1_DLLOFF_BIT]; // [R18]
    core_nxt.dllReady = mWritten[1] && !mExt1[X1_DLLOFF_BIT] && mLocked; // [R24]
    core_nxt.halfDrive = mWritten[1] && mExt1[X1_HALF_BIT]; // [R18]
    core_nxt.postedColumnDelay = mWritten[1] ? mExt1[X1_PCD_LSB +: 3] : 3'h0; // [R18]
    core_nxt.termCode = mWritten[1] ? {mExt1[X1_TERM1_BIT], mExt1[X1_TERM0_BIT]}
                                    : 2'h0; // [R18]
    core_nxt.calControl = mWritten[1] ? mExt1[X1_CAL_LSB +: 3] : CAL_EXIT; // [R18]
    core_nxt.maskEnable = !rdStrobe; // [R21] [R22]
    core_nxt.readOnlyStrobeOn = rdStrobe; // [R22]
    core_nxt.readStrobeCompOn = rdStrobe && !mExt1[X1_NSTRB_BIT]; // [R22]
    core_nxt.strobeCompOn = !(mWritten[1] && mExt1[X1_NSTRB_BIT]); // [R22]
    core_nxt.ext2Value = mExt2;
    core_nxt.ext3Value = mExt3;
    if (!nrst) begin
      core_nxt = '0;
      core_nxt.maskEnable = 1'b1;
      core_nxt.strobeCompOn = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    core_r <= core_nxt;
  end

  assign modeValid = core_r.modeValid;
  assign ext1Valid = core_r.ext1Valid;
  assign ext2Valid = core_r.ext2Valid;
  assign ext3Valid = core_r.ext3Valid;
  assign burstEight = core_r.burstEight;
  assign burstInterleave = core_r.burstInterleave;
  assign readLatency = core_r.readLatency;
  assign writeRecovery = core_r.writeRecovery;
  assign modeError = core_r.modeError;
  assign dllEnabled = core_r.dllEnabled;
  assign dllReady = core_r.dllReady;
  assign halfDrive = core_r.halfDrive;
  assign postedColumnDelay = core_r.postedColumnDelay;
  assign termCode = core_r.termCode;
  assign calControl = core_r.calControl;
  assign maskEnable = core_r.maskEnable;
  assign readOnlyStrobeOn = core_r.readOnlyStrobeOn;
  assign readStrobeCompOn = core_r.readStrobeCompOn;
  assign strobeCompOn = core_r.strobeCompOn;
  assign ext2Value = core_r.ext2Value;
  assign ext3Value = core_r.ext3Value;

endmodule // dmr_mode_regs

// file: dmr_mode_regs_chk.sv
// checker for the mode register block outputs
// assumes it is bound onto dmr_mode_regs; every property runs on mclk
`timescale 1ns/100ps
module dmr_mode_regs_chk #(
  parameter int BYTE_WIDE = 1,
  parameter int LOCK_CYCLES = 200
) (
  input wire logic mclk, // system clock
  input wire logic nrst, // reset, active low
  input wire logic modeValid, // main written
  input wire logic ext1Valid, // ext one written
  input wire logic burstEight, // burst eight
  input wire logic [2:0] readLatency, // latency code
  input wire logic [2:0] writeRecovery, // recovery code
  input wire logic modeError, // illegal setting
  input wire logic dllEnabled, // loop enabled
  input wire logic dllReady, // loop settled
  input wire logic halfDrive, // half driver
  input wire logic [2:0] calControl, // calibration code
  input wire logic maskEnable, // mask pin active
  input wire logic readOnlyStrobeOn, // read strobe on
  input wire logic readStrobeCompOn, // its complement on
  input wire logic strobeCompOn // data strobe complement on
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_mode_held;
    modeValid ##1 modeValid;
  endsequence

  a_mode_sticky: assert property (modeValid |-> s_mode_held)
    else $error("main register valid dropped");
  a_unset_mode: assert property (!modeValid |-> !burstEight && readLatency == 3'h0
    && writeRecovery == 3'h0) else $error("main fields set before write");
  a_unset_ext1: assert property (!ext1Valid |-> !halfDrive && calControl == 3'h0
    && strobeCompOn && !dllEnabled) else $error("ext one fields set before write");
  a_ready_enabled: assert property (dllReady |-> dllEnabled)
    else $error("loop ready while disabled");
  a_mask_rstrobe: assert property (maskEnable != readOnlyStrobeOn)
    else $error("mask and read strobe disagree");
  a_rstrobe_part: assert property (readOnlyStrobeOn |-> BYTE_WIDE != 0)
    else $error("read strobe on a wide part");
  a_strobe_matrix: assert property (readStrobeCompOn == (readOnlyStrobeOn && strobeCompOn))
    else $error("strobe matrix mismatch");
  a_error_cause: assert property (modeError |-> modeValid || ext1Valid)
    else $error("error without any write");
  a_reset_values: assert property (disable iff (1'b0) !nrst |=> maskEnable
    && strobeCompOn && !modeValid && !ext1Valid && !dllReady)
    else $error("outputs not at reset values");
endmodule // dmr_mode_regs_chk

bind dmr_mode_regs dmr_mode_regs_chk #(.BYTE_WIDE(BYTE_WIDE), .LOCK_CYCLES(LOCK_CYCLES))
  u_dmr_mode_regs_chk (.*);

// file: dmr_ctrl_model.sv
// controller-side model driving the command pins
// assumes the bench calls its tasks after reset; pins change on falling cmdClk
`timescale 1ns/100ps
module dmr_ctrl_model #(
  parameter int PERIOD_NS = 160 // command clock period in ns
) (
  output logic cke, // clock enable
  input wire logic cmdClk, // command clock
  output logic csN, // chip select, active low
  output logic rasN, // row strobe, active low
  output logic casN, // column strobe, active low
  output logic weN, // write enable, active low
  output logic [2:0] ba, // bank address
  output logic [15:0] addr // address pins
);
  // power-up and idle waits rounded up to whole command clocks, never shortened
  localparam int PWR_WAIT = (200000 + PERIOD_NS - 1) / PERIOD_NS;
  localparam int IDLE_WAIT = (400 + PERIOD_NS - 1) / PERIOD_NS;

  initial begin
    cke = 1'b0;
    {csN, rasN, casN, weN} = 4'hF;
    ba = 3'h0;
    addr = 16'h0000;
  end
  // power-up wait with cke low, then idle clocks with cke high
  task automatic start;
    repeat (PWR_WAIT) @(negedge cmdClk);
    cke = 1'b1;
    repeat (IDLE_WAIT) @(negedge cmdClk);
  endtask
  // one command, then a deselect clock so commands sit two clocks apart
  task automatic cmd(input logic [3:0] code, input logic [2:0] b, input logic [15:0] a);
    @(negedge cmdClk);
    {csN, rasN, casN, weN} = code;
    ba = b;
    addr = a;
    @(negedge cmdClk);
    {csN, rasN, casN, weN} = 4'hF;
    ba = ~b;
    addr = ~a;
  endtask
endmodule // dmr_ctrl_model

// file: dmr_mode_regs_tb_top.sv
// self-checking bench for the mode register block
// assumes a free-running command clock; pins come from the controller model
`timescale 1ns/100ps
module dmr_mode_regs_tb_top;
  import dmr_pkg::*;
  logic mclk, nrst, cmdClk, cke, csN, rasN, casN, weN;
  logic [2:0] ba;
  logic [15:0] addr;
  logic modeValid, ext1Valid, ext2Valid, ext3Valid, burstEight, burstInterleave, modeError;
  logic dllEnabled, dllReady, halfDrive, maskEnable, readOnlyStrobeOn, readStrobeCompOn;
  logic strobeCompOn;
  logic [2:0] readLatency, writeRecovery, postedColumnDelay, calControl;
  logic [1:0] termCode;
  logic [MR_W-1:0] ext2Value, ext3Value;
  logic [15:0] bad [3] = '{16'h0441, 16'h04C2, 16'h2442};
  logic [15:0] x1;
  int failures, checked, cycles;

  dmr_mode_regs #(.BYTE_WIDE(1), .LOCK_CYCLES(40)) u_dmr_mode_regs (.*);
  dmr_ctrl_model u_dmr_ctrl_model (.*);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    cmdClk = 1'b0;
    #37;
    forever #80 cmdClk = ~cmdClk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // longest crossing delay plus margin
  task automatic settle;
    repeat (10) @(posedge cmdClk);
    @(negedge mclk);
  endtask
  task automatic wr(input logic [2:0] b, input logic [15:0] a);
    u_dmr_ctrl_model.cmd(4'h0, b, a);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    failures = 0;
    checked = 0;
    cycles = 0;
    // long enough for four command clock edges as well
    repeat (13) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    chk(maskEnable, 16'h0001); chk(strobeCompOn, 16'h0001);
    chk(modeValid, 16'h0000); chk(ext1Valid, 16'h0000);
    repeat (4) @(posedge cmdClk);
    wr(3'h0, 16'h0043);
    settle;
    chk(modeValid, 16'h0000);
    $display("test reset and refused write done");
    u_dmr_ctrl_model.start;
    u_dmr_ctrl_model.cmd(4'h2, 3'h0, 16'h0400);
    wr(3'h2, 16'h0080);
    wr(3'h3, 16'h0000);
    wr(3'h1, 16'h0000);
    wr(3'h0, 16'h0142);
    settle;
    chk(ext2Valid, 16'h0001); chk(ext2Value, 16'h0080);
    chk(ext3Valid, 16'h0001); chk(ext3Value, 16'h0000);
    chk(ext1Valid, 16'h0001); chk(dllEnabled, 16'h0001);
    chk(readLatency, 16'h0004); chk(burstEight, 16'h0000);
    chk(dllReady, 16'h0000);
    u_dmr_ctrl_model.cmd(4'h2, 3'h0, 16'h0400);
    u_dmr_ctrl_model.cmd(4'h1, 3'h0, 16'h0000);
    u_dmr_ctrl_model.cmd(4'h1, 3'h0, 16'h0FFF);
    repeat (40) @(posedge cmdClk);
    chk(dllReady, 16'h0001);
    chk(readLatency, 16'h0004);
    wr(3'h0, 16'h0E4B);
    settle;
    chk(burstEight, 16'h0001); chk(burstInterleave, 16'h0001);
    chk(writeRecovery, 16'h0007);
    chk(modeError, 16'h0000); chk(dllReady, 16'h0001);
    // calibration only once the loop has had its settling clocks since being enabled
    repeat (DLL_LOCK_CYCLES) @(posedge cmdClk);
    wr(3'h1, 16'h03EE);
    settle;
    chk(calControl, 16'h0007); chk(postedColumnDelay, 16'h0005);
    // exit after default and a settle; the trailing deselect clock covers the command gap
    wr(3'h1, 16'h006E);
    settle;
    chk(calControl, 16'h0000); chk(halfDrive, 16'h0001);
    $display("test init sequence done");
    foreach (bad[k]) begin
      wr(3'h0, bad[k]);
      settle;
      chk(modeError, 16'h0001);
    end
    wr(3'h0, 16'h0643);
    settle;
    chk(modeError, 16'h0000);
    $display("test main fields done");
    for (int i = 0; i < 4; i++) begin
      x1 = 16'h006E | 16'(i << 10);
      wr(3'h1, x1);
      settle;
      chk(readOnlyStrobeOn, i[1]); chk(maskEnable, !i[1]);
      chk(strobeCompOn, !i[0]); chk(readStrobeCompOn, i == 2);
      chk(halfDrive, 16'h0001); chk(termCode, 16'h0003);
      chk(postedColumnDelay, 16'h0005);
    end
    $display("test strobe matrix done");
    wr(3'h1, 16'h0246);
    settle;
    chk(calControl, 16'h0004); chk(postedColumnDelay, 16'h0005);
    wr(3'h1, 16'h006E);
    settle;
    chk(calControl, 16'h0000); chk(postedColumnDelay, 16'h0005);
    wr(3'h1, 16'h006F);
    settle;
    chk(dllEnabled, 16'h0000); chk(dllReady, 16'h0000);
    $display("test calibration and loop done");
    end_of_test;
  end
endmodule // dmr_mode_regs_tb_top
